// *** pkg/gdfc_pkg.sv ***
// package: register map, field layout, timing constants and carrier types of the gate drive fault control
package gdfc_pkg;

  // register byte addresses (word aligned)
  localparam logic [7:0] GDFC_ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] GDFC_ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] GDFC_ADDR_STAT   = 8'h08;
  localparam logic [7:0] GDFC_ADDR_CLEAR  = 8'h0c;

  // control one field positions
  localparam int GDFC_C1_PWM_LO      = 0;
  localparam int GDFC_C1_STP_BIT     = 3;
  localparam int GDFC_C1_DTM_BIT     = 4;
  localparam int GDFC_C1_DT6_LO      = 5;
  localparam int GDFC_C1_DEAD_LO     = 8;
  localparam int GDFC_C1_WIN_LO      = 16;
  localparam int GDFC_C1_SDI_LO      = 24;

  // ic_control_two field positions
  localparam int GDFC_C2_GAIN_LO     = 0;
  localparam int GDFC_C2_REF_BIT     = 4;
  localparam int GDFC_C2_EN_BIT      = 5;

  // clear register command bit
  localparam int GDFC_CLR_BIT        = 0;

  // reset values
  localparam logic [31:0] GDFC_CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] GDFC_CTRL2_RST = 32'h0000_0000;

  // input mode encodings
  localparam logic [2:0] GDFC_PWM_SIX    = 3'h0;

  // amplifier settings
  localparam logic [3:0] GDFC_GAIN_MAX   = 4'h8;
  localparam logic       GDFC_REF_HALF   = 1'b0;

  // shutdown timing and clock period in ns
  localparam int GDFC_CLK_NS         = 50;
  localparam int GDFC_T_SDD_NS       = 500;
  localparam int GDFC_T_SD_NS        = 2000;
  localparam int GDFC_SDD_CYC        = (GDFC_T_SDD_NS + GDFC_CLK_NS - 1) / GDFC_CLK_NS;
  localparam int GDFC_SD_CYC         = (GDFC_T_SD_NS + GDFC_CLK_NS - 1) / GDFC_CLK_NS;

  // deglitch times in ns
  localparam int GDFC_T_DG_NS        = 10000;
  localparam int GDFC_DG_CYC         = (GDFC_T_DG_NS + GDFC_CLK_NS - 1) / GDFC_CLK_NS;

  // shutdown stage shared by all three gate pairs
  typedef enum logic [1:0] {GDFC_SINK_NONE, GDFC_SINK_STRONG, GDFC_SINK_PROG, GDFC_SINK_SEMI} gdfc_sink_t;

  // gate drive command of one half-bridge
  typedef struct packed {
    logic high_on;
    logic low_on;
    logic high_strong_pd;
    logic low_strong_pd;
  } gdfc_gate_t;

  // latched fault flags
  typedef struct packed {
    logic       shoot_through_fault_flag;
    logic       overdrive_pump_uv_flag;
    logic       main_supply_uv_fault;
    logic       gate_supply_uv_fault;
    logic [2:0] bootstrap_uv_fault;
  } gdfc_flags_t;

endpackage

// *** rtl/gdfc_phase.sv ***
// one half-bridge: shoot-through block, deadtime and strong pull-down window
module gdfc_phase
  import gdfc_pkg::*;
#(
  parameter int CW = 8
)(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // inputs and configuration
  input  wire logic          high_side_input,
  input  wire logic          low_side_input,
  input  wire logic          six_mode,
  input  wire logic          dt_monitor,
  input  wire logic [CW-1:0] dead_cycles,
  input  wire logic [CW-1:0] window_cycles,
  input  wire logic          force_off,
  // results
  output gdfc_gate_t         gate,
  output logic               shoot_through
);
  gdfc_gate_t      gate_q, gate_d;
  logic [CW-1:0]   dt_q, dt_d;
  logic [CW-1:0]   hw_q, hw_d;
  logic [CW-1:0]   lw_q, lw_d;
  logic            st_q, st_d;
  logic            h_req, l_req, need_dt;

  always_comb
  begin
    st_d   = six_mode && high_side_input && low_side_input;
    h_req  = high_side_input && !st_d;
    l_req  = low_side_input && !st_d;
    // outside six-input mode deadtime always applies; monitor bits only matter in six-input mode
    need_dt = !six_mode || dt_monitor;
    dt_d   = (dt_q != '0) ? dt_q - CW'(1) : '0;
    if ((gate_q.high_on && !h_req) || (gate_q.low_on && !l_req))
      dt_d = dead_cycles;
    gate_d = gate_q;
    gate_d.high_on = h_req && !gate_q.low_on && (!need_dt || dt_q == '0 || gate_q.high_on);
    gate_d.low_on  = l_req && !gate_q.high_on && (!need_dt || dt_q == '0 || gate_q.low_on);
    // any edge of one gate's command before force_off starts the window on the other
    hw_d = (hw_q != '0) ? hw_q - CW'(1) : '0;
    lw_d = (lw_q != '0) ? lw_q - CW'(1) : '0;
    if (gate_d.low_on != gate_q.low_on)
      hw_d = window_cycles;
    if (gate_d.high_on != gate_q.high_on)
      lw_d = window_cycles;
    if (force_off)
    begin
      gate_d.high_on = 1'b0;
      gate_d.low_on  = 1'b0;
    end
    gate_d.high_strong_pd = (hw_d != '0) && !gate_d.high_on;
    gate_d.low_strong_pd  = (lw_d != '0) && !gate_d.low_on;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gate_q <= '0;
      dt_q   <= '0;
      hw_q   <= '0;
      lw_q   <= '0;
      st_q   <= 1'b0;
    end
    else
    begin
      gate_q <= gate_d;
      dt_q   <= dt_d;
      hw_q   <= hw_d;
      lw_q   <= lw_d;
      st_q   <= st_d;
    end
  end

  assign gate          = gate_q;
  assign shoot_through = st_q;
endmodule // gdfc_phase

// *** rtl/gdfc_top.sv ***
// top: register slave, fault latches, shutdown sequencer and three phases
module gdfc_top
  import gdfc_pkg::*;
#(
  parameter int DG_CYC = GDFC_DG_CYC
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pwm inputs and pins
  input  wire logic [2:0]  high_side_input,
  input  wire logic [2:0]  low_side_input,
  input  wire logic        driver_off_pin,
  input  wire logic        sleep_n,
  // analog monitor comparators
  input  wire logic        main_supply_low,
  input  wire logic        gate_supply_low,
  input  wire logic [2:0]  bootstrap_low,
  // gate drive
  output logic [2:0]       high_gate_out,
  output logic [2:0]       low_gate_out,
  output logic [2:0]       high_strong_pd,
  output logic [2:0]       low_strong_pd,
  output gdfc_sink_t       sink_stage,
  output logic [3:0]       shutdown_sink_current,
  output logic [2:0]       low_semi_pd,
  // supplies, amplifier and fault
  output logic             charge_pump_en,
  output logic             current_sense_amp_en,
  output logic [3:0]       current_sense_amp_gain,
  output logic             current_sense_amp_ref,
  output logic             fault_out_n
);
  localparam int DGW = $clog2(DG_CYC + 1);
  localparam int SQW = 8;

  // refuse settings the counters cannot hold
  if (DG_CYC < 1)
  begin : g_dg_chk
    $error("deglitch count must be at least one");
  end
  if (GDFC_SD_CYC >= 2 ** SQW || GDFC_SDD_CYC >= GDFC_SD_CYC)
  begin : g_sq_chk
    $error("shutdown count too wide or stages out of order");
  end

  logic [31:0]   ctrl1_q, ctrl1_d;
  logic [31:0]   ctrl2_q, ctrl2_d;
  gdfc_flags_t   flg_q, flg_d;
  logic [31:0]   rdata_q, rdata_d;
  logic          wait_q, wait_d;
  logic [DGW-1:0] dg_q [5], dg_d [5];
  logic [4:0]    mon, hit;
  logic [2:0]    st_raw;
  gdfc_gate_t    ph [3];
  logic          clr, sd_fault, off_now;
  gdfc_sink_t    stg_q, stg_d;
  logic [SQW-1:0] sq_q, sq_d;
  logic [2:0]    hg_q, hg_d, lg_q, lg_d, hs_q, hs_d, ls_q, ls_d, semi_q, semi_d;
  logic          cp_q, cp_d, fo_q, fo_d;

  // register decode used by writes; reads decode with a case
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign mon = {bootstrap_low, gate_supply_low, main_supply_low};

  always_comb
  begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    rdata_d = rdata_q;
    // one wait cycle per access: the request is answered on its second edge
    wait_d  = !((avs_read || avs_write) && wait_q);
    clr     = 1'b0;
    if (avs_write && !wait_q)
    begin
      if (hit_addr(avs_address, GDFC_ADDR_CTRL1))
        ctrl1_d = avs_writedata;
      if (hit_addr(avs_address, GDFC_ADDR_CTRL2))
      begin
        ctrl2_d = {26'h0, avs_writedata[5:0]};
        if (avs_writedata[3:0] > GDFC_GAIN_MAX)
          ctrl2_d[3:0] = GDFC_GAIN_MAX;
      end
      if (hit_addr(avs_address, GDFC_ADDR_CLEAR))
        clr = avs_writedata[GDFC_CLR_BIT];
    end
    // latch on the first edge so data already stand when waitrequest is seen low
    if (avs_read && wait_q)
    begin
      case (avs_address)
        GDFC_ADDR_CTRL1: rdata_d = ctrl1_q;
        GDFC_ADDR_CTRL2: rdata_d = ctrl2_q;
        GDFC_ADDR_STAT:  rdata_d = {22'h0, stg_q, 1'b0, flg_q};
        default:         rdata_d = 32'h0;
      endcase
    end
  end

  // deglitch counters: restart on any early release
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      hit[i]  = mon[i] && (dg_q[i] == DGW'(DG_CYC));
      dg_d[i] = !mon[i] ? '0 : (hit[i] ? dg_q[i] : dg_q[i] + DGW'(1));
    end
  end

  always_comb
  begin
    flg_d = flg_q;
    // clear first, so a fault seen in the same cycle still latches
    if (clr)
      flg_d = '0;
    if (hit[0])
      flg_d.main_supply_uv_fault = 1'b1;
    if (hit[1])
      flg_d.gate_supply_uv_fault = 1'b1;
    flg_d.bootstrap_uv_fault = flg_d.bootstrap_uv_fault | hit[4:2];
    if (ctrl1_q[GDFC_C1_STP_BIT] == 1'b0 && st_raw != '0)
      flg_d.shoot_through_fault_flag = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ph
      gdfc_phase #(.CW(8)) gdfc_phase_i (
        .clk           (clk),
        .rst           (rst),
        .high_side_input (high_side_input[g]),
        .low_side_input  (low_side_input[g]),
        .six_mode      (ctrl1_q[GDFC_C1_PWM_LO +: 3] == GDFC_PWM_SIX),
        .dt_monitor    (!ctrl1_q[GDFC_C1_DTM_BIT] && ctrl1_q[GDFC_C1_DT6_LO +: 2] == 2'h0),
        .dead_cycles   (ctrl1_q[GDFC_C1_DEAD_LO +: 8]),
        .window_cycles (ctrl1_q[GDFC_C1_WIN_LO +: 8]),
        .force_off     (sd_fault || driver_off_pin || !sleep_n),
        .gate          (ph[g]),
        .shoot_through (st_raw[g])
      );
    end
  endgenerate

  // any latched shutdown fault keeps gates down; the pump flag only reports
  assign sd_fault = flg_q.main_supply_uv_fault || flg_q.gate_supply_uv_fault ||
                    (flg_q.bootstrap_uv_fault != '0);
  assign off_now  = sd_fault || driver_off_pin || !sleep_n;

  always_comb
  begin
    stg_d = stg_q;
    sq_d  = (sq_q != '0) ? sq_q - SQW'(1) : '0;
    case (stg_q)
      GDFC_SINK_NONE:
        if (off_now)
        begin
          stg_d = GDFC_SINK_STRONG;
          sq_d  = SQW'(GDFC_SDD_CYC);
        end
      GDFC_SINK_STRONG:
        if (sq_q == SQW'(1))
        begin
          stg_d = GDFC_SINK_PROG;
          sq_d  = SQW'(GDFC_SD_CYC - GDFC_SDD_CYC);
        end
      GDFC_SINK_PROG:
        if (sq_q == SQW'(1))
          stg_d = GDFC_SINK_SEMI;
      GDFC_SINK_SEMI:
        if (!off_now)
          stg_d = GDFC_SINK_NONE;
      default:
        stg_d = GDFC_SINK_NONE;
    endcase
    for (int i = 0; i < 3; i++)
    begin
      // driver-off acts combinationally so it does not wait on the phase pipeline
      hg_d[i] = ph[i].high_on && !driver_off_pin && !off_now;
      lg_d[i] = ph[i].low_on && !driver_off_pin && !off_now;
      hs_d[i] = ph[i].high_strong_pd;
      ls_d[i] = ph[i].low_strong_pd;
      semi_d[i] = !sleep_n || stg_d == GDFC_SINK_SEMI;
    end
    cp_d = sleep_n && !flg_q.main_supply_uv_fault && !flg_q.gate_supply_uv_fault;
    fo_d = !(sd_fault || flg_q.overdrive_pump_uv_flag || flg_q.shoot_through_fault_flag);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_q <= GDFC_CTRL1_RST;
      ctrl2_q <= GDFC_CTRL2_RST;
      flg_q   <= '0;
      flg_q.overdrive_pump_uv_flag <= 1'b1;
      rdata_q <= '0;
      wait_q  <= 1'b1;
      stg_q   <= GDFC_SINK_NONE;
      sq_q    <= '0;
      hg_q    <= '0;
      lg_q    <= '0;
      hs_q    <= '0;
      ls_q    <= '0;
      semi_q  <= '0;
      cp_q    <= 1'b0;
      fo_q    <= 1'b0;
      for (int i = 0; i < 5; i++)
        dg_q[i] <= '0;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      flg_q   <= flg_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
      stg_q   <= stg_d;
      sq_q    <= sq_d;
      hg_q    <= hg_d;
      lg_q    <= lg_d;
      hs_q    <= hs_d;
      ls_q    <= ls_d;
      semi_q  <= semi_d;
      cp_q    <= cp_d;
      fo_q    <= fo_d;
      for (int i = 0; i < 5; i++)
        dg_q[i] <= dg_d[i];
    end
  end

  assign avs_readdata           = rdata_q;
  assign avs_waitrequest        = wait_q;
  assign high_gate_out          = hg_q;
  assign low_gate_out           = lg_q;
  assign high_strong_pd         = hs_q;
  assign low_strong_pd          = ls_q;
  assign sink_stage             = stg_q;
  assign shutdown_sink_current  = ctrl1_q[GDFC_C1_SDI_LO +: 4];
  assign low_semi_pd            = semi_q;
  assign charge_pump_en         = cp_q;
  assign current_sense_amp_en   = ctrl2_q[GDFC_C2_EN_BIT];
  assign current_sense_amp_gain = ctrl2_q[GDFC_C2_GAIN_LO +: 4];
  assign current_sense_amp_ref  = ctrl2_q[GDFC_C2_REF_BIT];
  assign fault_out_n            = fo_q;
endmodule // gdfc_top

// *** sim/gdfc_pwm_model.sv ***
// model of the external controller pwm unit feeding the six gate inputs
module gdfc_pwm_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // wanted levels from the sequence
  input  wire logic [2:0] hi_cmd,
  input  wire logic [2:0] lo_cmd,
  // pwm pins
  output logic [2:0]      high_side_input,
  output logic [2:0]      low_side_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // timer-driven outputs change only on clock edges, like a real pwm peripheral
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      high_side_input <= 3'h0;
      low_side_input  <= 3'h0;
    end
    else
    begin
      high_side_input <= hi_cmd;
      low_side_input  <= lo_cmd;
    end
  end
endmodule // gdfc_pwm_model

// *** sim/gdfc_top_checker.sv ***
// checker: concurrent properties on the gate drive fault control ports
module gdfc_top_checker
#(
  parameter int DG_CYC = 4
)(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // bus
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  // pins
  input wire logic [2:0]          high_side_input,
  input wire logic [2:0]          low_side_input,
  input wire logic                driver_off_pin,
  input wire logic                sleep_n,
  input wire logic                main_supply_low,
  input wire logic                gate_supply_low,
  input wire logic [2:0]          bootstrap_low,
  // outputs
  input wire logic [2:0]          high_gate_out,
  input wire logic [2:0]          low_gate_out,
  input wire logic [2:0]          high_strong_pd,
  input wire gdfc_pkg::gdfc_sink_t sink_stage,
  input wire logic [2:0]          low_semi_pd,
  input wire logic                charge_pump_en,
  input wire logic                fault_out_n
);
  import gdfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  int sup_q, sup_d, bst_q, bst_d;
  // saturating run-length of low comparators; counts past the deglitch stay harmless
  always_comb
  begin
    sup_d = (main_supply_low || gate_supply_low) ? ((sup_q < 1000) ? sup_q + 1 : sup_q) : 0;
    bst_d = bootstrap_low[0] ? ((bst_q < 1000) ? bst_q + 1 : bst_q) : 0;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sup_q <= 0;
      bst_q <= 0;
    end
    else
    begin
      sup_q <= sup_d;
      bst_q <= bst_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_driver_off_pin_gates: assert property (driver_off_pin |=> high_gate_out == 3'h0 && low_gate_out == 3'h0)
    else $error("gate on after driver off");
  chk_no_cross: assert property ((high_gate_out & low_gate_out) == 3'h0)
    else $error("both gates of a bridge on");
  chk_stp_block: assert property ((high_side_input[0] && low_side_input[0])[*3] |->
    !high_gate_out[0] && !low_gate_out[0]) else $error("shoot-through not blocked");
  chk_pd_window: assert property ($rose(low_gate_out[0]) |-> ##[0:2] high_strong_pd[0])
    else $error("no strong pull-down on opposite gate");
  chk_sink_strong: assert property (sink_stage == GDFC_SINK_STRONG |-> ##[1:10] sink_stage != GDFC_SINK_STRONG)
    else $error("strong sink too long");
  chk_sink_prog: assert property (sink_stage == GDFC_SINK_PROG |-> ##[1:30] sink_stage != GDFC_SINK_PROG)
    else $error("programmed sink too long");
  chk_sink_order: assert property ($changed(sink_stage) && sink_stage == GDFC_SINK_PROG |->
    $past(sink_stage) == GDFC_SINK_STRONG) else $error("programmed sink not after strong");
  chk_sleep_semi: assert property (!sleep_n |=> low_semi_pd == 3'h7)
    else $error("no semi pull-down in sleep");
  chk_supply_uv: assert property (sup_q == DG_CYC + 6 |->
    !fault_out_n && !charge_pump_en && high_gate_out == 3'h0) else $error("supply undervoltage not acted on");
  chk_bootstrap_uv_fault: assert property (bst_q == DG_CYC + 6 |->
    !fault_out_n && high_gate_out == 3'h0 && low_gate_out == 3'h0) else $error("bootstrap undervoltage not acted on");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  cover property (sink_stage == GDFC_SINK_SEMI);
  cover property (sup_q == DG_CYC + 6);
  cover property (avs_read && !avs_waitrequest);
endmodule // gdfc_top_checker

bind gdfc_top gdfc_top_checker #(.DG_CYC(DG_CYC)) gdfc_top_checker_i (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .high_side_input(high_side_input),
  .low_side_input(low_side_input), .driver_off_pin(driver_off_pin), .sleep_n(sleep_n),
  .main_supply_low(main_supply_low), .gate_supply_low(gate_supply_low), .bootstrap_low(bootstrap_low),
  .high_gate_out(high_gate_out), .low_gate_out(low_gate_out), .high_strong_pd(high_strong_pd),
  .sink_stage(sink_stage), .low_semi_pd(low_semi_pd), .charge_pump_en(charge_pump_en), .fault_out_n(fault_out_n));

// *** sim/gdfc_top_tb.sv ***
// testbench: registers, pwm, shutdown and undervoltage scenarios of the gate drive fault control
module gdfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gdfc_pkg::*;
  localparam int DG = 4;
  logic clk = 0, rst = 1, rd = 0, wr = 0, drv_off = 0, sleep_n = 1, main_low = 0, gate_low = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] hi_cmd = 3'h0, lo_cmd = 3'h0, bst_low = 3'h0, hsi, lsi, hgo, lgo, hpd, lpd, semi;
  logic waitreq, pump, amp_en, amp_ref, flt_n;
  logic [3:0] sdi, gain;
  gdfc_sink_t stage;
  logic [63:0] exp_q[$];
  int miscompares = 0, tests_run = 0;
  always #25 clk = ~clk;
  gdfc_pwm_model gdfc_pwm_model_i (.clk(clk), .rst(rst), .hi_cmd(hi_cmd), .lo_cmd(lo_cmd),
    .high_side_input(hsi), .low_side_input(lsi));
  gdfc_top #(.DG_CYC(DG)) gdfc_top_i (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq), .high_side_input(hsi),
    .low_side_input(lsi), .driver_off_pin(drv_off), .sleep_n(sleep_n), .main_supply_low(main_low),
    .gate_supply_low(gate_low), .bootstrap_low(bst_low), .high_gate_out(hgo), .low_gate_out(lgo),
    .high_strong_pd(hpd), .low_strong_pd(lpd), .sink_stage(stage), .shutdown_sink_current(sdi), .low_semi_pd(semi),
    .charge_pump_en(pump), .current_sense_amp_en(amp_en), .current_sense_amp_gain(gain),
    .current_sense_amp_ref(amp_ref), .fault_out_n(flt_n));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // request launched one edge after entry, so back-to-back calls never touch a strobe twice at one edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20)
    begin
      cmp("waitrequest", 32'h0, 32'h1);
      test_done;
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    exp_q.push_back({m, e});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic dwell(input gdfc_sink_t s, output int n);
    n = 0;
    while (stage === s && n < 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic set_uv(input int k, input logic v);
    if (k == 0) main_low <= v;
    else if (k == 1) gate_low <= v;
    else bst_low <= {2'b00, v};
  endtask
  // read results are judged where they appear, against the oldest note
  always @(posedge clk)
  begin : mon
    logic [63:0] x;
    if (rd && waitreq === 1'b0)
    begin
      x = exp_q.pop_front();
      cmp("readdata", x[31:0] & x[63:32], rdata & x[63:32]);
    end
  end
  initial
  begin
    #2_000_000;
    cmp("timeout", 32'h0, 32'h1);
    test_done;
  end
  initial
  begin
    logic [31:0] v, c1;
    logic [31:0] st;
    int n;
    v = $urandom(59);
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    cmp("amp_en", 32'h0, amp_en);
    cmp("fault_out_n", 32'h0, flt_n);
    rdx(GDFC_ADDR_CTRL1, GDFC_CTRL1_RST);
    rdx(GDFC_ADDR_CTRL2, GDFC_CTRL2_RST);
    rdx(GDFC_ADDR_STAT, 32'h20);
    rdx(8'h10, 32'h0);
    bus(GDFC_ADDR_CLEAR, 1'b1, 32'h1);
    rdx(GDFC_ADDR_STAT, 32'h0);
    cyc(2);
    cmp("fault_out_n", 32'h1, flt_n);
    for (int g = 0; g < 16; g++)
    begin
      v = ($urandom() & 32'h30) | g;
      bus(GDFC_ADDR_CTRL2, 1'b1, v);
      rdx(GDFC_ADDR_CTRL2, (g > 8) ? ((v & 32'h30) | 32'h8) : v);
      cmp("amp_gain", (g > 8) ? 32'h8 : g, gain);
      cmp("amp_ref", v[4], amp_ref);
      cmp("amp_en", v[5], amp_en);
    end
    c1 = (($urandom() & 32'hf) << 24) | 32'h0005_0800;
    bus(GDFC_ADDR_CTRL1, 1'b1, c1);
    rdx(GDFC_ADDR_CTRL1, c1);
    cmp("sink_current", c1[27:24], sdi);
    for (int m = 0; m < 6; m++)
    begin
      bus(GDFC_ADDR_CTRL1, 1'b1, c1 | m | ((m != 0) ? 32'h8 : 32'h0));
      hi_cmd <= 3'h1;
      n = 0;
      repeat (8)
      begin
        @(posedge clk);
        if (lpd[0] === 1'b1) n++;
      end
      if (m == 0) cmp("low_strong_pd_cycles", 32'h5, n);
      hi_cmd <= 3'h0;
      lo_cmd <= 3'h1;
      cyc(5);
      cmp("low_gate_early", 32'h0, lgo[0]);
      n = 0;
      repeat (30)
      begin
        @(posedge clk);
        if (hpd[0] === 1'b1) n++;
      end
      cmp("low_gate", 32'h1, lgo[0]);
      if (m == 0) cmp("strong_pd_cycles", 32'h5, n);
      lo_cmd <= 3'h0;
      cyc(4);
    end
    bus(GDFC_ADDR_CTRL1, 1'b1, c1);
    hi_cmd <= 3'h1;
    lo_cmd <= 3'h1;
    cyc(6);
    cmp("gates_both_high", 32'h0, {hgo[0], lgo[0]});
    rdx(GDFC_ADDR_STAT, 32'h40, 32'h7f);
    cmp("fault_out_n", 32'h0, flt_n);
    lo_cmd <= 3'h0;
    cyc(4);
    bus(GDFC_ADDR_CLEAR, 1'b1, 32'h1);
    rdx(GDFC_ADDR_STAT, 32'h0, 32'h7f);
    cyc(60);
    drv_off <= 1'b1;
    cyc(2);
    cmp("gates_driver_off", 32'h0, {hgo, lgo});
    n = 0;
    while (stage !== GDFC_SINK_STRONG && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    dwell(GDFC_SINK_STRONG, n);
    cmp("strong_cycles", GDFC_SDD_CYC, n);
    dwell(GDFC_SINK_PROG, n);
    cmp("prog_cycles", GDFC_SD_CYC - GDFC_SDD_CYC, n);
    cyc(2);
    cmp("sink_stage", GDFC_SINK_SEMI, stage);
    cmp("semi_pd", 32'h7, semi);
    drv_off <= 1'b0;
    cyc(60);
    for (int k = 0; k < 3; k++)
    begin
      st = (k == 0) ? 32'h10 : (k == 1) ? 32'h08 : 32'h01;
      repeat (2)
      begin
        set_uv(k, 1'b1);
        cyc(DG - 1);
        set_uv(k, 1'b0);
        cyc(1);
      end
      cyc(4);
      cmp("fault_out_n_dip", 32'h1, flt_n);
      set_uv(k, 1'b1);
      cyc(DG + 8);
      cmp("fault_out_n_uv", 32'h0, flt_n);
      cmp("pump_uv", (k == 2) ? 32'h1 : 32'h0, pump);
      set_uv(k, 1'b0);
      cyc(4);
      rdx(GDFC_ADDR_STAT, st, 32'h7f);
      cmp("gates_latched", 32'h0, hgo[0]);
      bus(GDFC_ADDR_CLEAR, 1'b1, 32'h1);
      rdx(GDFC_ADDR_STAT, 32'h0, 32'h7f);
      cyc(60);
    end
    hi_cmd <= 3'h0;
    sleep_n <= 1'b0;
    cyc(3);
    cmp("semi_sleep", 32'h7, semi);
    sleep_n <= 1'b1;
    cyc(3);
    test_done;
  end
endmodule // gdfc_top_tb
